// ===== hdl/power_ctl_pkg.sv
`default_nettype none
package power_ctl_pkg;

    localparam int unsigned CLOCK_MHZ = 250;
    // Reset pulse length for a button press or software request
    localparam int unsigned RESET_PULSE_NS = 1000;
    localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int unsigned RESET_CNT_W = 10;
    // Lead time of the suspend warning before the low-power state is entered
    localparam int unsigned WARN_LEAD_NS = 400;
    localparam int unsigned WARN_LEAD_CYC = (WARN_LEAD_NS * CLOCK_MHZ + 999) / 1000;
    localparam int unsigned WARN_CNT_W = 8;

    typedef enum logic [4:0] {
        ST_WAIT_POWER = 5'h01,
        ST_RUN = 5'h02,
        ST_WARN = 5'h04,
        ST_SLEEP_RAM = 5'h08,
        ST_SOFT_OFF = 5'h10
    } power_state_t;

    typedef enum logic [1:0] {
        TARGET_RAM = 2'h1,
        TARGET_OFF = 2'h2
    } sleep_target_t;

    // Carrier pins after synchronisation
    typedef struct packed {
        logic power_button_n;
        logic reset_button_n;
        logic supply_good;
        logic main_supply_ok;
        logic bus_wake_n;
        logic battery_low_n;
        logic lid_n;
        logic sleep_button_n;
    } carrier_pins_t;

    localparam int unsigned PIN_COUNT = 8;
    localparam carrier_pins_t PINS_IDLE = 8'hFF;
    // Supply inputs start as bad so nothing starts before they are really seen
    localparam carrier_pins_t PINS_RESET = 8'hCF;

    // Status handed to the operating system side
    typedef struct packed {
        logic power_button_event;
        logic sleep_button_event;
        logic lid_closed;
        logic power_fail;
        logic wake_event;
    } os_report_t;

endpackage : power_ctl_pkg
`default_nettype wire

// ===== hdl/module_power_state_reset_control.sv
// Contract
// [R1] Power button falling edge gives one event
// [R2] Power event wakes sleep, or powers down
// [R3] Reset button falling edge starts reset
// [R4] Held reset button does not hold reset
// [R5] Reset on button, supply bad, main low
// [R6] Reset also on watchdog and software request
// [R7] No startup until supply good high
// [R8] Carrier may hold supply good low
// [R9] Warn low before entering low-power state
// [R10] Suspend-to-RAM output low only in that state
// [R11] Carrier copy of RAM output cannot suspend
// [R12] Both soft-off outputs equal, low when off
// [R13] Watchdog expiry drives watchdog output
// [R14] Bus wake request wakes from low power
// [R15] Battery low reported as power fail
// [R16] Lid switch state reported to system
// [R17] Sleep button presses reported to system
// [R18] All pins pass two synchroniser flops
`timescale 1ns/1ps
`default_nettype none

module module_power_state_reset_control (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire power_ctl_pkg::carrier_pins_t pins_async,
    input wire logic watchdog_timeout,
    input wire logic software_reset_req,
    input wire logic sleep_request,
    input wire power_ctl_pkg::sleep_target_t sleep_target,
    output logic carrier_reset_out_n,
    output logic suspend_imminent_n,
    output logic sleep_ram_n,
    output logic soft_off_a_n,
    output logic soft_off_b_n,
    output logic watchdog_expired_out,
    output power_ctl_pkg::os_report_t os_report
);
    import power_ctl_pkg::*;

    carrier_pins_t sync1_q;
    carrier_pins_t sync2_q;
    carrier_pins_t prev_q;
    power_state_t state_q;
    power_state_t state_d;
    sleep_target_t target_q;
    logic [RESET_CNT_W-1:0] rst_cnt_q;
    logic [WARN_CNT_W-1:0] warn_cnt_q;
    logic power_fall;
    logic reset_fall;
    logic sleep_fall;
    logic wake_any;
    logic level_reset;
    logic low_power_d;
    logic pulse_trigger;

    // Two flops per pin; the first is read only by the second
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_q <= PINS_RESET;
            sync2_q <= PINS_RESET;
            prev_q <= PINS_IDLE;
        end else if (clock_enable) begin
            sync1_q <= pins_async; // see [R18]
            sync2_q <= sync1_q; // see [R18]
            prev_q <= sync2_q;
        end
    end

    assign power_fall = prev_q.power_button_n && !sync2_q.power_button_n; // see [R1]
    assign reset_fall = prev_q.reset_button_n && !sync2_q.reset_button_n; // see [R3]
    assign sleep_fall = prev_q.sleep_button_n && !sync2_q.sleep_button_n;
    assign wake_any = power_fall || sleep_fall || !sync2_q.bus_wake_n; // see [R2] see [R14]
    // Supply faults are levels; the reset stays on as long as they last
    assign level_reset = !sync2_q.supply_good || !sync2_q.main_supply_ok; // see [R5] see [R7]
    // Warning stays low through the sleep states, not only ahead of them
    assign low_power_d = (state_d == ST_WARN) || (state_d == ST_SLEEP_RAM) || (state_d == ST_SOFT_OFF); // see [R9]
    assign pulse_trigger = reset_fall || watchdog_timeout || software_reset_req; // see [R3] see [R6]

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_WAIT_POWER: begin
                if (!level_reset) begin
                    state_d = ST_RUN; // see [R7]
                end
            end
            ST_RUN: begin
                if (power_fall) begin
                    state_d = ST_WARN; // see [R2]
                end else if (sleep_request || sleep_fall) begin
                    state_d = ST_WARN; // see [R17]
                end
            end
            ST_WARN: begin
                if (warn_cnt_q == '0) begin
                    state_d = (target_q == TARGET_OFF) ? ST_SOFT_OFF : ST_SLEEP_RAM;
                end
            end
            ST_SLEEP_RAM, ST_SOFT_OFF: begin
                if (wake_any) begin
                    state_d = ST_RUN; // see [R2] see [R14]
                end
            end
            default: begin
                state_d = ST_WAIT_POWER;
            end
        endcase
        // Supply loss drops any running state back to waiting
        if (level_reset && state_q != ST_SOFT_OFF && state_q != ST_SLEEP_RAM) begin
            state_d = ST_WAIT_POWER; // see [R7]
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= ST_WAIT_POWER;
        end else if (clock_enable) begin
            state_q <= state_d;
        end
    end

    // Power button always means soft off; sleep button means RAM unless the power button fell in the same cycle; requests use the target
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            target_q <= TARGET_RAM;
        end else if (clock_enable && state_q == ST_RUN) begin
            if (power_fall) begin
                target_q <= TARGET_OFF; // see [R2]
            end else if (sleep_fall) begin
                target_q <= TARGET_RAM;
            end else if (sleep_request) begin
                target_q <= sleep_target;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            warn_cnt_q <= WARN_CNT_W'(WARN_LEAD_CYC);
        end else if (clock_enable) begin
            if (state_q != ST_WARN) begin
                warn_cnt_q <= WARN_CNT_W'(WARN_LEAD_CYC);
            end else if (warn_cnt_q != '0) begin
                warn_cnt_q <= warn_cnt_q - 1'b1;
            end
        end
    end

    // Edge events start a fixed pulse, so a held button cannot extend it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rst_cnt_q <= '0;
        end else if (clock_enable) begin
            if (pulse_trigger) begin
                rst_cnt_q <= RESET_CNT_W'(RESET_PULSE_CYC); // see [R3] see [R4] see [R6]
            end else if (rst_cnt_q != '0) begin
                rst_cnt_q <= rst_cnt_q - 1'b1; // see [R4]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            carrier_reset_out_n <= 1'b0;
        end else if (clock_enable) begin
            carrier_reset_out_n <= !(level_reset || rst_cnt_q != '0 || state_q == ST_WAIT_POWER); // see [R5] see [R6]
        end
    end

    // Outputs come from state only; nothing read back from these pins
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            suspend_imminent_n <= 1'b1;
        end else if (clock_enable) begin
            suspend_imminent_n <= !low_power_d; // see [R9]
        end
    end

    // The carrier may feed an inverted copy to its supply; it is never read back
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sleep_ram_n <= 1'b1;
        end else if (clock_enable) begin
            sleep_ram_n <= !(state_d == ST_SLEEP_RAM); // see [R10]
        end
    end

    // Both soft-off pins come from one compare so they cannot drift apart
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            soft_off_a_n <= 1'b1;
            soft_off_b_n <= 1'b1;
        end else if (clock_enable) begin
            soft_off_a_n <= !(state_d == ST_SOFT_OFF); // see [R12]
            soft_off_b_n <= !(state_d == ST_SOFT_OFF); // see [R12]
        end
    end

    // Sticky until the timeout input drops and the reset pulse has ended; software clears the source
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            watchdog_expired_out <= 1'b0;
        end else if (clock_enable) begin
            watchdog_expired_out <= watchdog_timeout || (watchdog_expired_out && rst_cnt_q != '0); // see [R13]
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            os_report <= '0;
        end else if (clock_enable) begin
            os_report.power_button_event <= power_fall; // see [R1]
            os_report.sleep_button_event <= sleep_fall; // see [R17]
            os_report.lid_closed <= !sync2_q.lid_n; // see [R16]
            os_report.power_fail <= !sync2_q.battery_low_n; // see [R15]
            os_report.wake_event <= wake_any && (state_q == ST_SLEEP_RAM || state_q == ST_SOFT_OFF); // see [R14]
        end
    end

endmodule : module_power_state_reset_control
`default_nettype wire

// ===== test/module_power_state_reset_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module module_power_state_reset_control_props (
    input wire logic clock,
    input wire logic reset_n,
    input wire power_ctl_pkg::carrier_pins_t pins_async,
    input wire logic watchdog_timeout,
    input wire logic software_reset_req,
    input wire logic carrier_reset_out_n,
    input wire logic suspend_imminent_n,
    input wire logic sleep_ram_n,
    input wire logic soft_off_a_n,
    input wire logic soft_off_b_n,
    input wire logic watchdog_expired_out,
    input wire power_ctl_pkg::os_report_t os_report
);
    import power_ctl_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_power_event: assert property ($fell(pins_async.power_button_n) && carrier_reset_out_n
        && suspend_imminent_n |-> ##[2:5] os_report.power_button_event) else $error("no power event");
    chk_button_reset: assert property ($fell(pins_async.reset_button_n)
        |-> ##[2:5] !carrier_reset_out_n) else $error("no button reset");
    chk_reset_ends: assert property ($fell(carrier_reset_out_n) && pins_async.supply_good
        && pins_async.main_supply_ok |-> ##[200:300] carrier_reset_out_n) else $error("reset stuck");
    chk_supply_reset: assert property ((!pins_async.supply_good) [*4]
        |=> !carrier_reset_out_n) else $error("no supply reset");
    chk_sw_reset: assert property (software_reset_req |-> ##[1:3] !carrier_reset_out_n)
        else $error("no software reset");
    chk_startup_gate: assert property (carrier_reset_out_n |-> $past(pins_async.supply_good, 3))
        else $error("reset released without supply good");
    chk_warn_lead: assert property ($fell(soft_off_a_n) || $fell(sleep_ram_n)
        |-> !$past(suspend_imminent_n, 99)) else $error("warning too short");
    chk_off_equal: assert property (soft_off_a_n == soft_off_b_n) else $error("soft-off differ");
    chk_wdt_out: assert property (watchdog_timeout |-> ##[1:2] watchdog_expired_out)
        else $error("no watchdog output");
    cover property ($fell(soft_off_a_n));
    cover property ($fell(sleep_ram_n));
    cover property (os_report.wake_event);
endmodule : module_power_state_reset_control_props
bind module_power_state_reset_control module_power_state_reset_control_props u_props (.*);
`default_nettype wire

// ===== test/carrier_model.sv
`timescale 1ns/1ps
`default_nettype none
module carrier_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire power_ctl_pkg::carrier_pins_t want,
    output power_ctl_pkg::carrier_pins_t pins
);
    import power_ctl_pkg::*;
    // Supply good stays low a while after reset, as a loading carrier would
    int unsigned hold_q;
    always_ff @(posedge clock) begin
        hold_q <= !reset_n ? 0 : (hold_q < 20 ? hold_q + 1 : hold_q);
    end
    // The sleep-RAM line is neither observed nor driven back
    always_comb begin
        pins = want;
        pins.supply_good = want.supply_good && (hold_q == 20);
    end
endmodule : carrier_model
`default_nettype wire

// ===== test/tb_module_power_state_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_module_power_state_reset_control;
    import power_ctl_pkg::*;
    logic clock = 0;
    logic reset_n = 0;
    logic [2:0] req = 0;
    sleep_target_t sleep_target = TARGET_RAM;
    logic [7:0] want = PINS_IDLE;
    carrier_pins_t pins;
    wire [10:0] outs;
    int num_errors = 0;
    int total_checks = 0;
    int mst = 0;
    logic [31:0] r;
    initial forever #2 clock = ~clock;
    carrier_model u_carrier (.clock(clock), .reset_n(reset_n), .want(want), .pins(pins));
    module_power_state_reset_control DUT (.clock(clock), .reset_n(reset_n), .clock_enable(1'b1),
        .pins_async(pins), .watchdog_timeout(req[2]), .software_reset_req(req[1]), .sleep_request(req[0]),
        .sleep_target(sleep_target), .carrier_reset_out_n(outs[10]), .suspend_imminent_n(outs[9]),
        .sleep_ram_n(outs[8]), .soft_off_a_n(outs[7]), .soft_off_b_n(outs[6]),
        .watchdog_expired_out(outs[5]), .os_report(outs[4:0]));
    task automatic chk(input logic s, input logic e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic report_and_stop();
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // Bounded wait for one output bit; running out is a mismatch and ends the run
    task automatic waitv(input int i, input logic v, input int lim);
        int n;
        #1;
        for (n = 0; n < lim && outs[i] !== v; n++) @(posedge clock) #1;
        chk(outs[i], v);
        if (outs[i] !== v) report_and_stop();
    endtask : waitv
    task automatic setp(input int b, input logic v);
        @(posedge clock) want[b] <= v;
    endtask : setp
    task automatic pulse(input int i);
        @(posedge clock) req[i] <= 1'b1;
        @(posedge clock) req[i] <= 1'b0;
    endtask : pulse
    // Reference state: 0 running, 1 suspend-to-RAM, 2 soft-off
    task automatic cmpst();
        chk(outs[8], mst != 1);
        chk(outs[7], mst != 2);
        chk(outs[6], mst != 2);
    endtask : cmpst
    initial begin
        r = $urandom(10710);
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (10) @(posedge clock);
        #1 chk(outs[10], 1'b0);
        waitv(10, 1, 300);
        setp(6, 0);
        waitv(10, 0, 6);
        waitv(10, 1, 300);
        setp(6, 1);
        for (int i = 1; i < 3; i++) begin
            pulse(i);
            waitv(10, 0, 6);
            chk(outs[5], i == 2);
            waitv(10, 1, 300);
        end
        setp(7, 0);
        waitv(4, 1, 8);
        waitv(9, 0, 4);
        setp(7, 1);
        mst = 2;
        waitv(7, 0, 120);
        cmpst();
        setp(7, 0);
        mst = 0;
        waitv(7, 1, 10);
        cmpst();
        setp(7, 1);
        for (int t = 1; t < 3; t++) begin
            @(posedge clock) sleep_target <= sleep_target_t'(t);
            pulse(0);
            mst = t;
            waitv(9 - t, 0, 120);
            cmpst();
            setp(3, 0);
            waitv(0, 1, 8);
            mst = 0;
            waitv(9 - t, 1, 10);
            setp(3, 1);
        end
        setp(0, 0);
        waitv(3, 1, 8);
        setp(0, 1);
        for (int b = 4; b < 6; b++) begin
            setp(b, 0);
            waitv(10, 0, 6);
            setp(b, 1);
            waitv(10, 1, 400);
        end
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            setp(1, r[0]);
            setp(2, r[1]);
            repeat (6) @(posedge clock);
            #1 chk(outs[2], !r[0]);
            chk(outs[1], !r[1]);
        end
        report_and_stop();
    end
endmodule : tb_module_power_state_reset_control
`default_nettype wire
